// *** include/slave_buffer_pkg.sv ***
// Constants shared by the parallel slave buffer status block.
// Behaviour
// R1 - Input all-full set when every input byte full
// R2 - Host write to full input sets sticky overflow
// R3 - Per-byte input full flags in bits 11..8
// R4 - Output all-empty when every output byte empty
// R5 - Host read of empty output sets underflow
// R6 - Per-byte output empty flags, bits 3..0, reset one
// R7 - Host byte read sets empty flags of its whole word pair
// R8 - Bits 13,12,5,4 read zero, writes ignored
package slave_buffer_pkg;
   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] status_offset = 8'h00;
   localparam logic [7:0] irq_status_offset = 8'h04;
   localparam logic [7:0] irq_mask_offset = 8'h08;
   localparam logic [7:0] input_data_offset = 8'h0c;
   localparam logic [7:0] output_data_offset = 8'h10;
   // ----------------------------------------------------------------
   // Status field positions
   // ----------------------------------------------------------------
   localparam int input_all_full_bit = 15;
   localparam int input_overflow_bit = 14;
   localparam int input_byte_full_lsb = 8;
   localparam int output_all_empty_bit = 7;
   localparam int output_underflow_bit = 6;
   localparam int output_byte_empty_lsb = 0;
   localparam int num_bytes = 4;
   // ----------------------------------------------------------------
   // Interrupt status bit positions and reset values
   // ----------------------------------------------------------------
   localparam int irq_overflow_bit = 0;
   localparam int irq_underflow_bit = 1;
   localparam int irq_input_full_bit = 2;
   localparam int irq_output_empty_bit = 3;
   localparam int irq_width = 4;
   localparam logic [3:0] input_full_reset = 4'h0;
   localparam logic [3:0] output_empty_reset = 4'hf;
   localparam logic [3:0] irq_reset = 4'h0;
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// *** include/host_port_if.sv ***
// Interface carrying host byte accesses and buffer flags between modules.
`timescale 1ns/1ps
interface host_port_if;
   logic [3:0] host_wr_lane;
   logic [3:0] host_rd_lane;
   logic [3:0] sw_wr_lane;
   logic [3:0] sw_rd_lane;
   logic [3:0] input_byte_full;
   logic [3:0] output_byte_empty;
   logic input_overflow_event;
   logic output_underflow_event;
   modport core (input host_wr_lane, input host_rd_lane, input sw_wr_lane, input sw_rd_lane,
      output input_byte_full, output output_byte_empty, output input_overflow_event,
      output output_underflow_event);
   modport ctrl (output host_wr_lane, output host_rd_lane, output sw_wr_lane, output sw_rd_lane,
      input input_byte_full, input output_byte_empty, input input_overflow_event,
      input output_underflow_event);
endinterface

// *** hw/buffer_flags.sv ***
// Per-byte full and empty flag keeping for the host port buffers.
`timescale 1ns/1ps
module buffer_flags
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Flag traffic
   host_port_if.core port
);
   // Widens a lane mask to the whole word pair it touches.
   function automatic logic [3:0] pair_mask(input logic [3:0] lanes);
      pair_mask = {{2{|lanes[3:2]}}, {2{|lanes[1:0]}}};
   endfunction

   logic [3:0] full_reg;
   logic [3:0] empty_reg;

   // ----------------------------------------------------------------
   // Input byte full flags
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         full_reg <= slave_buffer_pkg::input_full_reset;
      else
         // A host write in the same cycle as a pair clear keeps the new byte.
         full_reg <= (full_reg & ~pair_mask(port.sw_rd_lane)) | port.host_wr_lane; // see R3 see R7
   end

   // ----------------------------------------------------------------
   // Output byte empty flags
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         empty_reg <= slave_buffer_pkg::output_empty_reset; // see R6
      else
         empty_reg <= (empty_reg & ~port.sw_wr_lane) | pair_mask(port.host_rd_lane); // see R6 see R7
   end

   assign port.input_byte_full = full_reg;
   assign port.output_byte_empty = empty_reg;
   assign port.input_overflow_event = |(port.host_wr_lane & full_reg & ~pair_mask(port.sw_rd_lane)); // see R2
   assign port.output_underflow_event = |(port.host_rd_lane & empty_reg); // see R5
endmodule

// *** hw/slave_buffer_status.sv ***
// Top of the parallel slave buffer status block with its AXI4-Lite slave.
`timescale 1ns/1ps
module slave_buffer_status
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Host side byte strobes
   input wire logic [3:0] host_wr_strobe,
   input wire logic [3:0] host_rd_strobe,
   // Flags and interrupt
   output logic input_all_full,
   output logic output_all_empty,
   output logic irq
);
   typedef enum logic [1:0] {wr_idle, wr_resp} wr_state_t;

   host_port_if port ();

   wr_state_t wr_state_reg;
   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic ovf_reg;
   logic unf_reg;
   logic [3:0] irq_status_reg;
   logic [3:0] irq_mask_reg;
   logic all_full_d_reg;
   logic all_empty_d_reg;
   logic do_write;
   logic do_read;
   logic [15:0] status_word;
   logic [3:0] irq_events;

   buffer_flags flags
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .port(port)
   );

   assign port.host_wr_lane = host_wr_strobe;
   assign port.host_rd_lane = host_rd_strobe;
   assign do_write = (wr_state_reg == wr_idle) && aw_held_reg && w_held_reg;
   assign do_read = s_axi_arvalid && s_axi_arready;
   assign port.sw_wr_lane = (do_write && awaddr_reg == slave_buffer_pkg::output_data_offset) ?
      wstrb_reg : 4'h0;
   assign port.sw_rd_lane = (do_read && s_axi_araddr == slave_buffer_pkg::input_data_offset) ?
      4'hf : 4'h0;

   // ----------------------------------------------------------------
   // Status word assembly
   // ----------------------------------------------------------------
   always_comb
   begin
      status_word = 16'h0000; // see R8
      status_word[slave_buffer_pkg::input_all_full_bit] = &port.input_byte_full; // see R1
      status_word[slave_buffer_pkg::input_overflow_bit] = ovf_reg;
      status_word[slave_buffer_pkg::input_byte_full_lsb +: 4] = port.input_byte_full; // see R3
      status_word[slave_buffer_pkg::output_all_empty_bit] = &port.output_byte_empty; // see R4
      status_word[slave_buffer_pkg::output_underflow_bit] = unf_reg;
      status_word[slave_buffer_pkg::output_byte_empty_lsb +: 4] = port.output_byte_empty; // see R6
   end

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         wr_state_reg <= wr_idle;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= slave_buffer_pkg::resp_okay;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         case (wr_state_reg)
            wr_idle:
               if (do_write)
               begin
                  aw_held_reg <= 1'b0;
                  w_held_reg <= 1'b0;
                  s_axi_bvalid <= 1'b1;
                  if (awaddr_reg == slave_buffer_pkg::status_offset ||
                      awaddr_reg == slave_buffer_pkg::irq_status_offset ||
                      awaddr_reg == slave_buffer_pkg::irq_mask_offset ||
                      awaddr_reg == slave_buffer_pkg::input_data_offset ||
                      awaddr_reg == slave_buffer_pkg::output_data_offset)
                     s_axi_bresp <= slave_buffer_pkg::resp_okay;
                  else
                     s_axi_bresp <= slave_buffer_pkg::resp_slverr;
                  wr_state_reg <= wr_resp;
               end
            wr_resp:
               if (s_axi_bready)
               begin
                  s_axi_bvalid <= 1'b0;
                  wr_state_reg <= wr_idle;
               end
            default:
               wr_state_reg <= wr_idle;
         endcase
      end
   end

   // Ready is a registered level so the outputs stay flop-driven.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && wr_state_reg == wr_idle;
         s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && wr_state_reg == wr_idle;
      end
   end

   // ----------------------------------------------------------------
   // Sticky error flags, software clears by writing one
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ovf_reg <= 1'b0;
         unf_reg <= 1'b0;
      end
      else
      begin
         // Set wins over a clear landing in the same cycle.
         if (port.input_overflow_event) // see R2
            ovf_reg <= 1'b1;
         else if (do_write && awaddr_reg == slave_buffer_pkg::status_offset && wstrb_reg[1] &&
                  wdata_reg[slave_buffer_pkg::input_overflow_bit])
            ovf_reg <= 1'b0;
         if (port.output_underflow_event) // see R5
            unf_reg <= 1'b1;
         else if (do_write && awaddr_reg == slave_buffer_pkg::status_offset && wstrb_reg[0] &&
                  wdata_reg[slave_buffer_pkg::output_underflow_bit])
            unf_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         all_full_d_reg <= 1'b0;
         all_empty_d_reg <= 1'b1;
      end
      else
      begin
         all_full_d_reg <= status_word[slave_buffer_pkg::input_all_full_bit];
         all_empty_d_reg <= status_word[slave_buffer_pkg::output_all_empty_bit];
      end
   end

   always_comb
   begin
      irq_events = 4'h0;
      irq_events[slave_buffer_pkg::irq_overflow_bit] = port.input_overflow_event;
      irq_events[slave_buffer_pkg::irq_underflow_bit] = port.output_underflow_event;
      irq_events[slave_buffer_pkg::irq_input_full_bit] =
         status_word[slave_buffer_pkg::input_all_full_bit] && !all_full_d_reg;
      irq_events[slave_buffer_pkg::irq_output_empty_bit] =
         status_word[slave_buffer_pkg::output_all_empty_bit] && !all_empty_d_reg;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_status_reg <= slave_buffer_pkg::irq_reset;
         irq_mask_reg <= slave_buffer_pkg::irq_reset;
      end
      else
      begin
         if (do_write && awaddr_reg == slave_buffer_pkg::irq_status_offset && wstrb_reg[0])
            irq_status_reg <= (irq_status_reg & ~wdata_reg[3:0]) | irq_events;
         else
            irq_status_reg <= irq_status_reg | irq_events;
         if (do_write && awaddr_reg == slave_buffer_pkg::irq_mask_offset && wstrb_reg[0])
            irq_mask_reg <= wdata_reg[3:0];
      end
   end

   // ----------------------------------------------------------------
   // Read channel and flag outputs
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= slave_buffer_pkg::resp_okay;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !do_read;
         if (do_read)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= slave_buffer_pkg::resp_okay;
            if (s_axi_araddr == slave_buffer_pkg::status_offset)
               s_axi_rdata <= {16'h0000, status_word};
            else if (s_axi_araddr == slave_buffer_pkg::irq_status_offset)
               s_axi_rdata <= {28'h0000000, irq_status_reg};
            else if (s_axi_araddr == slave_buffer_pkg::irq_mask_offset)
               s_axi_rdata <= {28'h0000000, irq_mask_reg};
            else if (s_axi_araddr == slave_buffer_pkg::input_data_offset ||
                     s_axi_araddr == slave_buffer_pkg::output_data_offset)
               s_axi_rdata <= 32'h00000000;
            else
            begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= slave_buffer_pkg::resp_slverr;
            end
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         input_all_full <= 1'b0;
         output_all_empty <= 1'b1; // see R4
         irq <= 1'b0;
      end
      else
      begin
         input_all_full <= status_word[slave_buffer_pkg::input_all_full_bit]; // see R1
         output_all_empty <= status_word[slave_buffer_pkg::output_all_empty_bit]; // see R4
         irq <= |(irq_status_reg & irq_mask_reg);
      end
   end
endmodule

// *** test/buffer_status_sva.sv ***
// Port-level assertions for the slave buffer status block.
`timescale 1ns/1ps
module buffer_status_sva
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic s_axi_bvalid,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   // Host strobes and flags
   input wire logic [3:0] host_wr_strobe,
   input wire logic [3:0] host_rd_strobe,
   input wire logic input_all_full,
   input wire logic output_all_empty,
   input wire logic irq
);
   logic [7:0] rd_addr_reg;
   logic stat_rd;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   always_ff @(posedge aclk)
   begin
      if (s_axi_arvalid && s_axi_arready)
         rd_addr_reg <= s_axi_araddr;
   end
   assign stat_rd = s_axi_rvalid && rd_addr_reg == slave_buffer_pkg::status_offset;
   // The pins lag the status word by one cycle, hence the two-deep look back.
   a_full_rise:
      assert property ($rose(input_all_full) |-> $past(host_wr_strobe, 2) != 4'h0)
      else $error("All-full rose with no host write.");
   a_full_fall:
      assert property ($fell(input_all_full) && $past(aresetn) |->
         s_axi_rvalid || $past(s_axi_rvalid) || $past(s_axi_rvalid, 2)) else $error("All-full fell with no read.");
   a_empty_fall:
      assert property ($fell(output_all_empty) |->
         s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("All-empty fell with no write.");
   a_empty_rise:
      assert property ($rose(output_all_empty) && $past(aresetn) |-> $past(host_rd_strobe, 2) != 4'h0)
      else $error("All-empty rose with no host read.");
   a_reset_flags:
      assert property ($rose(aresetn) |-> output_all_empty && !input_all_full && !irq)
      else $error("Flag pins wrong after reset.");
   a_full_agg:
      assert property (stat_rd |-> s_axi_rdata[15] == &s_axi_rdata[11:8])
      else $error("All-full bit disagrees with byte bits.");
   a_empty_agg:
      assert property (stat_rd |-> s_axi_rdata[7] == &s_axi_rdata[3:0])
      else $error("All-empty bit disagrees with byte bits.");
   a_reserved_zero:
      assert property (stat_rd |-> {s_axi_rdata[31:16], s_axi_rdata[13:12], s_axi_rdata[5:4]} == 20'h00000)
      else $error("Reserved status bits not zero.");
   c_all_full: cover property ($rose(input_all_full));
   c_irq: cover property ($rose(irq));
   c_error_read: cover property (stat_rd && s_axi_rdata[14]);
endmodule

// *** test/host_model.sv ***
// Behavioural external host that pulses one byte strobe per access.
`timescale 1ns/1ps
module host_model
(
   // Clock
   input wire logic aclk,
   // Byte strobes
   output logic [3:0] host_wr_strobe = 4'h0,
   output logic [3:0] host_rd_strobe = 4'h0
);
   // The gap models a slow host; the trailing idle edge keeps two pulses apart.
   task automatic access(input logic rd, input logic [1:0] lane, input int gap);
      repeat (gap) @(posedge aclk);
      host_rd_strobe <= rd ? 4'h1 << lane : 4'h0;
      host_wr_strobe <= rd ? 4'h0 : 4'h1 << lane;
      @(posedge aclk);
      host_rd_strobe <= 4'h0;
      host_wr_strobe <= 4'h0;
      @(posedge aclk);
   endtask
endmodule

// *** test/tb.sv ***
// Self-checking testbench for the slave buffer status block.
`timescale 1ns/1ps
module tb;
   localparam logic [7:0] stat_a = slave_buffer_pkg::status_offset;
   localparam logic [7:0] irq_a = slave_buffer_pkg::irq_status_offset;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, input_all_full, output_all_empty, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
   logic [3:0] host_wr_strobe, host_rd_strobe;
   logic [31:0] s_axi_rdata, rd_data;
   int errors = 0, total_checks = 0, cycles = 0;
   always #25 aclk = ~aclk;
   slave_buffer_status u_slave_buffer_status
   (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .host_wr_strobe(host_wr_strobe), .host_rd_strobe(host_rd_strobe), .input_all_full(input_all_full),
      .output_all_empty(output_all_empty), .irq(irq)
   );
   host_model u_host (.aclk(aclk), .host_wr_strobe(host_wr_strobe), .host_rd_strobe(host_rd_strobe));
   // The whole run needs about a hundred cycles; the ceiling leaves ample margin.
   always @(posedge aclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         errors = errors + 1;
         tally_and_finish();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
         errors = errors + 1;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic aw_left;
      logic w_left;
      aw_left = 1'b1;
      w_left = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (aw_left || w_left)
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1)
            aw_left = 1'b0;
         if (s_axi_wready === 1'b1)
            w_left = 1'b0;
         s_axi_awvalid <= aw_left;
         s_axi_wvalid <= w_left;
      end
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      wr_resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      check(rd_data, exp);
   endtask
   task automatic test_reset();
      expect_reg(stat_a, 32'h0000008f);
      expect_reg(irq_a, 32'h00000000);
      check({31'h0, output_all_empty}, 32'h1);
      axi_write(stat_a, 32'hffffffff, 4'hf);
      check({30'h0, wr_resp}, {30'h0, slave_buffer_pkg::resp_okay});
      expect_reg(stat_a, 32'h0000008f);
      expect_reg(8'h40, 32'h00000000);
      check({30'h0, rd_resp}, {30'h0, slave_buffer_pkg::resp_slverr});
      axi_write(8'h40, 32'h00000001, 4'hf);
      check({30'h0, wr_resp}, {30'h0, slave_buffer_pkg::resp_slverr});
      expect_reg(stat_a, 32'h0000008f);
      $display("test_reset done");
   endtask
   task automatic test_input();
      for (int i = 0; i < 3; i++)
         u_host.access(1'b0, 2'(i), i);
      expect_reg(stat_a, 32'h0000078f);
      u_host.access(1'b0, 2'h3, 3);
      expect_reg(stat_a, 32'h00008f8f);
      check({31'h0, input_all_full}, 32'h1);
      u_host.access(1'b0, 2'h2, 0);
      expect_reg(stat_a, 32'h0000cf8f);
      expect_reg(slave_buffer_pkg::input_data_offset, 32'h00000000);
      expect_reg(stat_a, 32'h0000408f);
      check({31'h0, input_all_full}, 32'h0);
      axi_write(stat_a, 32'h00004000, 4'h2);
      expect_reg(stat_a, 32'h0000008f);
      $display("test_input done");
   endtask
   task automatic test_output();
      axi_write(slave_buffer_pkg::output_data_offset, 32'h5a5a5a5a, 4'hf);
      expect_reg(stat_a, 32'h00000000);
      check({31'h0, output_all_empty}, 32'h0);
      u_host.access(1'b1, 2'h2, 0);
      expect_reg(stat_a, 32'h0000000c);
      u_host.access(1'b1, 2'h3, 1);
      expect_reg(stat_a, 32'h0000004c);
      u_host.access(1'b1, 2'h0, 0);
      expect_reg(stat_a, 32'h000000cf);
      axi_write(slave_buffer_pkg::output_data_offset, 32'h00000000, 4'h2);
      axi_write(stat_a, 32'h00000040, 4'h1);
      expect_reg(stat_a, 32'h0000000d);
      $display("test_output done");
   endtask
   task automatic test_irq();
      expect_reg(irq_a, 32'h0000000f);
      check({31'h0, irq}, 32'h0);
      axi_write(slave_buffer_pkg::irq_mask_offset, 32'h00000002, 4'hf);
      expect_reg(slave_buffer_pkg::irq_mask_offset, 32'h00000002);
      check({31'h0, irq}, 32'h1);
      axi_write(irq_a, 32'h00000002, 4'hf);
      expect_reg(irq_a, 32'h0000000d);
      check({31'h0, irq}, 32'h0);
      $display("test_irq done");
   endtask
   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      test_reset();
      test_input();
      test_output();
      test_irq();
      tally_and_finish();
   end
endmodule
bind slave_buffer_status buffer_status_sva u_sva
(
   .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .host_wr_strobe(host_wr_strobe), .host_rd_strobe(host_rd_strobe),
   .input_all_full(input_all_full), .output_all_empty(output_all_empty), .irq(irq)
);
